// ===== src/csq_pkg.sv
// Shared constants, types and result encoding for the conversion sequencer.
// Assumes all counts are in master clock cycles unless named otherwise.
package csq_pkg;

  // Conversion sequence, in master clock cycles
  localparam int unsigned DELAY_CYCLES = 1182;
  localparam int unsigned HIGH_CYCLES  = 354;
  localparam int unsigned LOW_CYCLES   = 64;
  localparam int unsigned CONVERT_REQUEST_N_CYCLES  = DELAY_CYCLES + HIGH_CYCLES + LOW_CYCLES;
  localparam int unsigned READY_EARLY  = 2;
  localparam int unsigned WAKE_CYCLES  = 3083;

  localparam int unsigned CNT_W  = 11;
  localparam int unsigned WAKE_W = 12;

  localparam logic [CNT_W-1:0]  CONVERT_REQUEST_N_LAST  = CNT_W'(CONVERT_REQUEST_N_CYCLES - 1);
  localparam logic [CNT_W-1:0]  HIGH_START = CNT_W'(DELAY_CYCLES);
  localparam logic [CNT_W-1:0]  LOW_START  = CNT_W'(DELAY_CYCLES + HIGH_CYCLES);
  localparam logic [CNT_W-1:0]  EARLY_RISE = CNT_W'(CONVERT_REQUEST_N_CYCLES - READY_EARLY - 1);
  localparam logic [WAKE_W-1:0] WAKE_LAST  = WAKE_W'(WAKE_CYCLES - 1);

  // Clock source detection, in i_clk cycles
  localparam int unsigned OSC_DIV      = 4;
  localparam int unsigned OSC_W        = 3;
  localparam int unsigned IDLE_TIMEOUT = 32;
  localparam int unsigned IDLE_W       = 6;
  localparam logic [OSC_W-1:0]  OSC_LAST  = OSC_W'(OSC_DIV - 1);
  localparam logic [IDLE_W-1:0] IDLE_LAST = IDLE_W'(IDLE_TIMEOUT);

  // Result word
  localparam int unsigned WORD_W = 24;
  localparam int unsigned RAW_W  = 26;
  localparam int unsigned BIT_W  = 5;
  localparam logic [WORD_W-1:0] BIP_MAX = 24'h7fffff;
  localparam logic [WORD_W-1:0] BIP_MIN = 24'h800000;
  localparam logic [WORD_W-1:0] UNI_MAX = 24'hffffff;
  localparam logic [WORD_W-1:0] UNI_MIN = 24'h000000;
  localparam logic [BIT_W-1:0]  BITS_FULL = BIT_W'(WORD_W);

  localparam logic signed [RAW_W-1:0] RAW_BIP_MAX = {{(RAW_W-WORD_W){1'b0}}, BIP_MAX};
  localparam logic signed [RAW_W-1:0] RAW_BIP_MIN = {{(RAW_W-WORD_W){1'b1}}, BIP_MIN};
  localparam logic signed [RAW_W-1:0] RAW_UNI_MAX = {{(RAW_W-WORD_W){1'b0}}, UNI_MAX};
  localparam logic signed [RAW_W-1:0] RAW_UNI_MIN = {{(RAW_W-WORD_W){1'b0}}, UNI_MIN};

  typedef enum logic [1:0] {ST_IDLE, ST_CONVERT_REQUEST_N, ST_SLEEP, ST_WAKE} csq_state_t;

  // Clamp the wide filter value into the chosen output coding
  function automatic logic [WORD_W-1:0] csq_encode(input logic signed [RAW_W-1:0] raw,
                                                   input logic bipolar);
    logic [WORD_W-1:0] w;
    w = raw[WORD_W-1:0];
    if (bipolar) begin
      if (raw > RAW_BIP_MAX) begin
        w = BIP_MAX;
      end else if (raw < RAW_BIP_MIN) begin
        w = BIP_MIN;
      end
    end else begin
      if (raw > RAW_UNI_MAX) begin
        w = UNI_MAX;
      end else if (raw < RAW_UNI_MIN) begin
        w = UNI_MIN;
      end
    end
    return w;
  endfunction

endpackage

// ===== src/csq_clock_source.sv
// Master clock source selection: external edges or internal oscillator.
// Assumes i_mclk is already synchronous to i_clk.
`timescale 1ns/1ps
`default_nettype none
module csq_clock_source
  import csq_pkg::*;
(
  input  wire logic i_clk,     // system clock
  input  wire logic i_arst_n,  // async reset, active low
  input  wire logic i_mclk,    // master clock pin level
  output logic      o_tick,    // one pulse per master clock cycle
  output logic      o_osc_on,  // internal oscillator running
  output logic      o_ext_clk  // external clock detected
);

  logic              mclk_prev_reg, mclk_prev_next;
  logic [IDLE_W-1:0] idle_reg, idle_next;
  logic              ext_reg, ext_next;
  logic              osc_reg, osc_next;
  logic [OSC_W-1:0]  div_reg, div_next;
  logic              tick_reg, tick_next;
  logic              fall;

  always_comb begin
    fall           = mclk_prev_reg & ~i_mclk;
    mclk_prev_next = i_mclk;
    idle_next      = idle_reg;
    ext_next       = ext_reg;
    if (fall) begin
      idle_next = '0;
      ext_next  = 1'b1;
    end else if (idle_reg != IDLE_LAST) begin
      idle_next = IDLE_W'(idle_reg + 1);
    end else begin
      ext_next = 1'b0;
    end
    // Pin low and quiet starts the oscillator; pin high keeps it stopped
    osc_next = ~ext_next & ~i_mclk;
    div_next = '0;
    if (osc_reg) begin
      div_next = (div_reg == OSC_LAST) ? '0 : OSC_W'(div_reg + 1);
    end
    tick_next = ext_reg ? fall : (osc_reg && div_reg == OSC_LAST);
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mclk_prev_reg <= 1'b0;
      idle_reg      <= '0;
      ext_reg       <= 1'b0;
      osc_reg       <= 1'b0;
      div_reg       <= '0;
      tick_reg      <= 1'b0;
    end else begin
      mclk_prev_reg <= mclk_prev_next;
      idle_reg      <= idle_next;
      ext_reg       <= ext_next;
      osc_reg       <= osc_next;
      div_reg       <= div_next;
      tick_reg      <= tick_next;
    end
  end

  assign o_tick    = tick_reg;
  assign o_osc_on  = osc_reg;
  assign o_ext_clk = ext_reg;

  a_osc_off_ext: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    o_ext_clk |-> !o_osc_on) else $error("oscillator runs with external clock");

  a_high_no_tick: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (!ext_reg && i_mclk && mclk_prev_reg) |=> !o_tick)
    else $error("tick while master clock held high");

endmodule
`default_nettype wire

// ===== src/csq_serial_port.sv
// Self-clocked serial output of the result word, MSB first.
// Assumes i_tick marks master clock cycles; serial clock is half that rate.
`timescale 1ns/1ps
`default_nettype none
module csq_serial_port
  import csq_pkg::*;
(
  input  wire logic              i_clk,                    // system clock
  input  wire logic              i_arst_n,                 // async reset, active low
  input  wire logic              i_tick,                   // master clock enable
  input  wire logic              i_load,                   // new result pulse
  input  wire logic [WORD_W-1:0] i_word,                   // result word
  input  wire logic              i_cs_n,                   // chip select, active low
  input  wire logic              i_self_clocked_port_mode, // port drives its own clock
  output logic                   o_sdo,                    // serial data out
  output logic                   o_sdo_oe_n,               // data enable, low drives
  output logic                   o_sclk,                   // serial clock out
  output logic                   o_sclk_oe_n,              // clock enable, low drives
  output logic                   o_done                    // word fully shifted, pulse
);

  logic [WORD_W-1:0] sh_reg, sh_next;
  logic [BIT_W-1:0]  bits_reg, bits_next;
  logic              busy_reg, busy_next;
  logic              sclk_reg, sclk_next;
  logic              sdo_reg, sdo_next;
  logic              oe_n_reg, oe_n_next;
  logic              done_reg, done_next;
  logic              drive;

  always_comb begin
    drive     = ~i_cs_n & i_self_clocked_port_mode;
    sh_next   = sh_reg;
    bits_next = bits_reg;
    busy_next = busy_reg;
    sclk_next = sclk_reg;
    sdo_next  = sdo_reg;
    done_next = 1'b0;
    oe_n_next = ~drive;
    if (!drive) begin
      // Deselecting mid-word abandons the read; ready then rises early
      busy_next = 1'b0;
      sclk_next = 1'b0;
    end else if (i_load) begin
      sh_next   = i_word;
      bits_next = BITS_FULL;
      busy_next = 1'b1;
      sclk_next = 1'b0;
    end else if (busy_reg && i_tick) begin
      sclk_next = ~sclk_reg;
      if (!sclk_reg) begin
        if (bits_reg != '0) begin
          sdo_next  = sh_reg[WORD_W-1];
          sh_next   = {sh_reg[WORD_W-2:0], 1'b0};
          bits_next = BIT_W'(bits_reg - 1);
        end else begin
          busy_next = 1'b0;
          sclk_next = 1'b0;
          done_next = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sh_reg   <= '0;
      bits_reg <= '0;
      busy_reg <= 1'b0;
      sclk_reg <= 1'b0;
      sdo_reg  <= 1'b0;
      oe_n_reg <= 1'b1;
      done_reg <= 1'b0;
    end else begin
      sh_reg   <= sh_next;
      bits_reg <= bits_next;
      busy_reg <= busy_next;
      sclk_reg <= sclk_next;
      sdo_reg  <= sdo_next;
      oe_n_reg <= oe_n_next;
      done_reg <= done_next;
    end
  end

  assign o_sdo       = sdo_reg;
  assign o_sdo_oe_n  = oe_n_reg;
  assign o_sclk      = sclk_reg;
  assign o_sclk_oe_n = oe_n_reg;
  assign o_done      = done_reg;

  a_msb_order: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (drive && !i_load && busy_reg && i_tick && !sclk_reg && bits_reg != '0)
      |=> (o_sdo == $past(sh_reg[WORD_W-1]) && o_sclk))
    else $error("serial bit not MSB first on rising clock");

  a_port_release: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_cs_n |=> (o_sdo_oe_n && o_sclk_oe_n && !busy_reg))
    else $error("port driven while deselected");

endmodule
`default_nettype wire

// ===== src/csq_conversion_sequencer.sv
// Conversion sequencer top: start, phase timing, ready line, sleep and wake.
// Assumes host pins are synchronous to i_clk; master clock arrives on i_mclk.
//
// What this block does
// - A low convert request starts a conversion lasting 1600 master cycles.
// - Request held low converts back to back, ready falling every 1600 cycles.
// - Ready looped to request gives one conversion every 1602 cycles.
// - An asynchronous request may slip start by 0 to 4 cycles, up to 1604.
// - Shared clock and same-edge request or reset release keeps converters in step.
// - Host resets after power-up; reset initialises the conversion logic.
// - Sleep low enters low power; 3083 cycles wake delay before converting.
// - At conversion end the result loads into the port and ready falls.
// - Ready rises once every result bit has been shifted out.
// - Unread result with select low: ready rises two cycles before next end.
// - Ready falls again at the next end as the new result loads.
// - Delay 1182 to 1186 cycles, 354 high power, 64 low power, then ready.
// - Master clock pin tied low starts and uses the internal oscillator.
// - Toggling master clock stops the oscillator and drives the conversion.
// - Master clock held high stops all cycles, allowing cycle deletion.
// - Coding select pin level chooses the result encoding.
// - Low gives saturating straight binary; high gives saturating two's complement.
// - Self-clocked port with select low shifts result MSB first on rising edges.
`timescale 1ns/1ps
`default_nettype none
module csq_conversion_sequencer
  import csq_pkg::*;
(
  input  wire logic                      i_clk,                    // 20 MHz system clock
  input  wire logic                      i_arst_n,                 // async reset, active low
  input  wire logic                      i_mclk,                   // master clock pin
  input  wire logic                      i_convert_request_n,      // start request, low
  input  wire logic                      i_sleep_n,                // sleep request, low
  input  wire logic                      i_coding_select,          // high: bipolar
  input  wire logic                      i_self_clocked_port_mode, // port makes its clock
  input  wire logic                      i_cs_n,                   // chip select, low
  input  wire logic signed [csq_pkg::RAW_W-1:0] i_raw_result,      // filter output
  output logic                           o_ready_n,                // result ready, low
  output logic [csq_pkg::WORD_W-1:0]     o_result_word,            // latched result
  output logic                           o_high_power_phase,       // high-power phase
  output logic                           o_low_power_phase,        // low-power phase
  output logic                           o_sleeping,               // low-power sleep
  output logic                           o_osc_on,                 // internal oscillator on
  output logic                           o_sdo,                    // serial data
  output logic                           o_sdo_oe_n,               // data enable, low
  output logic                           o_sclk,                   // serial clock
  output logic                           o_sclk_oe_n               // clock enable, low
);

  logic tick;
  logic shift_done;

  csq_clock_source u_clk_src (
    .i_clk     (i_clk),
    .i_arst_n  (i_arst_n),
    .i_mclk    (i_mclk),
    .o_tick    (tick),
    .o_osc_on  (o_osc_on),
    .o_ext_clk ()
  );

  // Request synchroniser at the system rate; the sequencer reads it on ticks
  logic req_s1_reg, req_s1_next;
  logic req_s2_reg, req_s2_next;

  always_comb begin
    req_s1_next = i_convert_request_n;
    req_s2_next = req_s1_reg;
  end

  // Free-running stages see a looped-back release before the end tick, so the
  // loop stops there and restarts two ticks later: one conversion per 1602
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      req_s1_reg <= 1'b1;
      req_s2_reg <= 1'b1;
    end else begin
      req_s1_reg <= req_s1_next;
      req_s2_reg <= req_s2_next;
    end
  end

  // Sequencer state
  csq_state_t        state_reg, state_next;
  logic [CNT_W-1:0]  cnt_reg, cnt_next;
  logic [WAKE_W-1:0] wake_reg, wake_next;
  logic              start;
  logic              end_tick;

  always_comb begin
    start      = ~req_s2_reg;
    end_tick   = 1'b0;
    state_next = state_reg;
    cnt_next   = cnt_reg;
    wake_next  = wake_reg;
    case (state_reg)
      ST_IDLE: begin
        if (tick && start) begin
          state_next = ST_CONVERT_REQUEST_N;
          cnt_next   = '0;
        end
      end
      ST_CONVERT_REQUEST_N: begin
        if (tick) begin
          if (cnt_reg == CONVERT_REQUEST_N_LAST) begin
            end_tick = i_sleep_n;
            cnt_next = '0;
            // Request back high in time ends after one conversion
            if (!start) begin
              state_next = ST_IDLE;
            end
          end else begin
            cnt_next = CNT_W'(cnt_reg + 1);
          end
        end
      end
      ST_SLEEP: begin
        if (i_sleep_n) begin
          state_next = ST_WAKE;
          wake_next  = '0;
        end
      end
      default: begin
        if (tick) begin
          if (wake_reg == WAKE_LAST) begin
            state_next = ST_IDLE;
          end else begin
            wake_next = WAKE_W'(wake_reg + 1);
          end
        end
      end
    endcase
    // Sleep aborts anything in progress
    if (!i_sleep_n) begin
      state_next = ST_SLEEP;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_reg <= ST_IDLE;
      cnt_reg   <= '0;
      wake_reg  <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      wake_reg  <= wake_next;
    end
  end

  // Ready line, result latch and phase flags
  logic              ready_n_reg, ready_n_next;
  logic [WORD_W-1:0] word_reg, word_next;
  logic              load_reg, load_next;
  logic              high_reg, high_next;
  logic              low_reg, low_next;
  logic              sleep_reg, sleep_next;

  always_comb begin
    ready_n_next = ready_n_reg;
    word_next    = word_reg;
    load_next    = end_tick;
    if (shift_done) begin
      ready_n_next = 1'b1;
    end
    if (tick && state_reg == ST_CONVERT_REQUEST_N && cnt_reg == EARLY_RISE) begin
      ready_n_next = 1'b1;
    end
    if (state_next == ST_SLEEP) begin
      ready_n_next = 1'b1;
    end
    // A new result outranks any rise in the same cycle
    if (end_tick) begin
      ready_n_next = 1'b0;
      word_next    = csq_encode(i_raw_result, i_coding_select);
    end
    high_next  = (state_next == ST_CONVERT_REQUEST_N) && (cnt_next >= HIGH_START)
                 && (cnt_next < LOW_START);
    low_next   = (state_next == ST_CONVERT_REQUEST_N) && (cnt_next >= LOW_START);
    sleep_next = (state_next == ST_SLEEP);
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ready_n_reg <= 1'b1;
      word_reg    <= '0;
      load_reg    <= 1'b0;
      high_reg    <= 1'b0;
      low_reg     <= 1'b0;
      sleep_reg   <= 1'b0;
    end else begin
      ready_n_reg <= ready_n_next;
      word_reg    <= word_next;
      load_reg    <= load_next;
      high_reg    <= high_next;
      low_reg     <= low_next;
      sleep_reg   <= sleep_next;
    end
  end

  assign o_ready_n          = ready_n_reg;
  assign o_result_word      = word_reg;
  assign o_high_power_phase = high_reg;
  assign o_low_power_phase  = low_reg;
  assign o_sleeping         = sleep_reg;

  csq_serial_port u_port (
    .i_clk                    (i_clk),
    .i_arst_n                 (i_arst_n),
    .i_tick                   (tick),
    .i_load                   (load_reg),
    .i_word                   (word_reg),
    .i_cs_n                   (i_cs_n),
    .i_self_clocked_port_mode (i_self_clocked_port_mode),
    .o_sdo                    (o_sdo),
    .o_sdo_oe_n               (o_sdo_oe_n),
    .o_sclk                   (o_sclk),
    .o_sclk_oe_n              (o_sclk_oe_n),
    .o_done                   (shift_done)
  );

  // Helper: master cycles between successive ends in a back-to-back run
  logic [CNT_W-1:0] gap_reg;
  logic             chain_reg;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      gap_reg   <= '0;
      chain_reg <= 1'b0;
    end else begin
      if (end_tick) begin
        gap_reg   <= '0;
        chain_reg <= start;
      end else if (tick && gap_reg != '1) begin
        gap_reg <= CNT_W'(gap_reg + 1);
      end
      if (state_reg == ST_SLEEP) begin
        chain_reg <= 1'b0;
      end
    end
  end

  a_chain_period: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (end_tick && chain_reg) |-> gap_reg == CONVERT_REQUEST_N_LAST)
    else $error("back-to-back period is not 1600 cycles");

  a_chain_restart: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (end_tick && start) |=> (state_reg == ST_CONVERT_REQUEST_N && cnt_reg == '0))
    else $error("held request did not restart conversion");

  a_ready_load: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    end_tick |=> (!o_ready_n && o_result_word == csq_encode($past(i_raw_result),
                                                            $past(i_coding_select))))
    else $error("result not loaded with ready low");

  a_early_rise: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (tick && state_reg == ST_CONVERT_REQUEST_N && cnt_reg == EARLY_RISE && i_sleep_n)
      |=> o_ready_n) else $error("ready did not rise two cycles before end");

  a_phase_high: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    $rose(o_high_power_phase) |-> (cnt_reg == HIGH_START && !o_low_power_phase))
    else $error("high-power phase began at wrong count");

  a_phase_low: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    $fell(o_high_power_phase) && state_reg == ST_CONVERT_REQUEST_N |-> o_low_power_phase
      && cnt_reg == LOW_START) else $error("low-power phase did not follow");

  a_wake_hold: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (state_reg == ST_WAKE && wake_reg != WAKE_LAST) |=> state_reg != ST_CONVERT_REQUEST_N)
    else $error("conversion started during wake delay");

  a_sleep_enter: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    !i_sleep_n |=> (o_sleeping && o_ready_n && !o_high_power_phase))
    else $error("sleep did not enter low power");

  a_idle_start: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (state_reg == ST_IDLE && req_s2_reg) |=> state_reg != ST_CONVERT_REQUEST_N)
    else $error("start without synchronised request");

  a_loop_stop: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (end_tick && req_s2_reg) |=> state_reg == ST_IDLE)
    else $error("released request did not stop conversions");

  a_end_in_low: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    end_tick |-> o_low_power_phase)
    else $error("conversion ended outside low-power phase");

  a_sleep_quiet: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    o_sleeping |-> (!o_high_power_phase && !o_low_power_phase && o_ready_n))
    else $error("activity while sleeping");

  a_wake_idle: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (state_reg == ST_WAKE && tick && wake_reg == WAKE_LAST && i_sleep_n)
      |=> state_reg == ST_IDLE) else $error("wake delay did not end");

  a_start_tick: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (state_reg == ST_IDLE && state_next == ST_CONVERT_REQUEST_N) |-> tick)
    else $error("conversion started off a master tick");

endmodule
`default_nettype wire

// ===== tb/csq_host_model.sv
// Host model: master clock pin, reset, sleep and convert request.
// Assumes the bench steers it through its tasks and mode variables.
`timescale 1ns/1ps
`default_nettype none
module csq_host_model (
  input  wire logic i_clk,               // system clock
  input  wire logic i_ready_n,           // device ready, low
  output var logic  o_arst_n,            // reset, low
  output var logic  o_mclk,              // master clock pin
  output wire logic o_convert_request_n, // start request, low
  output var logic  o_sleep_n            // sleep, low
);
  logic [1:0] mclk_mode = 2'h0; // 0 toggles, 1 held low, 2 held high
  logic       loop_back = 1'b0;
  logic       req_n     = 1'b1;
  initial begin
    o_arst_n  = 1'b0;
    o_mclk    = 1'b0;
    o_sleep_n = 1'b1;
  end
  always @(negedge i_clk) begin
    o_mclk <= (mclk_mode == 2'h0) ? ~o_mclk : mclk_mode[1];
  end
  assign o_convert_request_n = loop_back ? i_ready_n : req_n;
  task automatic do_reset();
    o_arst_n = 1'b0;
    repeat (3) @(negedge i_clk);
    o_arst_n = 1'b1;
  endtask
  // Falls with a master falling edge; a negative length holds it low
  task automatic start(input int ticks);
    @(negedge i_clk iff o_mclk);
    req_n <= 1'b0;
    if (ticks >= 0) begin
      repeat (2 * ticks) @(negedge i_clk);
      req_n <= 1'b1;
    end
  endtask
  // Reset is left high for the whole nap
  task automatic nap(input int cycles);
    o_sleep_n = 1'b0;
    repeat (cycles) @(negedge i_clk);
    o_sleep_n = 1'b1;
  endtask
endmodule
`default_nettype wire

// ===== tb/csq_conversion_sequencer_tb_top.sv
// Bench: conversion timing, coding, serial read, sleep and clock source.
// Assumes the host model makes the master clock, one tick per two cycles.
`timescale 1ns/1ps
`default_nettype none
module csq_conversion_sequencer_tb_top;
  import csq_pkg::*;
  logic clk = 1'b0;
  logic arst_n, mclk, req_n, sleep_n, ready_n, hp, lp, slp, osc, sdo, oe_n, sclk, soe, r;
  logic coding = 1'b1;
  logic mode = 1'b0;
  logic cs_n = 1'b0;
  logic signed [RAW_W-1:0] raw = 26'sh1000000;
  logic [WORD_W-1:0] word, got;
  int fail_count = 0;
  int n_checks = 0;
  int hp_cyc, lp_cyc, c, d;
  initial forever #25 clk = ~clk;
  csq_host_model csq_host_model_inst (.i_clk(clk), .i_ready_n(ready_n), .o_arst_n(arst_n),
    .o_mclk(mclk), .o_convert_request_n(req_n), .o_sleep_n(sleep_n));
  csq_conversion_sequencer csq_conversion_sequencer_inst (.i_clk(clk), .i_arst_n(arst_n),
    .i_mclk(mclk), .i_convert_request_n(req_n), .i_sleep_n(sleep_n), .i_coding_select(coding),
    .i_self_clocked_port_mode(mode), .i_cs_n(cs_n), .i_raw_result(raw), .o_ready_n(ready_n),
    .o_result_word(word), .o_high_power_phase(hp), .o_low_power_phase(lp), .o_sleeping(slp),
    .o_osc_on(osc), .o_sdo(sdo), .o_sdo_oe_n(oe_n), .o_sclk(sclk), .o_sclk_oe_n(soe));
  always @(negedge clk) begin
    if (hp === 1'b1) hp_cyc++;
    if (lp === 1'b1) lp_cyc++;
  end
  task automatic give_verdict();
    $display("Checks %0d, errors %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] seen);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s: expected %0h, seen %0h", what, exp, seen);
    end
  endtask
  task automatic check_rng(input string what, input int lo, input int hi, input int seen);
    n_checks++;
    if (seen < lo || seen > hi) begin
      fail_count++;
      $display("Error %s: expected %0d..%0d, seen %0d", what, lo, hi, seen);
    end
  endtask
  task automatic wait_lvl(input logic lvl, input int bound, output int cyc);
    cyc = 0;
    while (ready_n !== lvl) begin
      @(negedge clk);
      cyc++;
      if (cyc > bound) begin
        fail_count++;
        $display("Error ready_n wait: expected %0b, seen %0b", lvl, ready_n);
        give_verdict();
      end
    end
  endtask
  // Fall-to-fall distance of the ready line, in cycles
  task automatic period(input int bound, output int cyc);
    int a;
    wait_lvl(1'b1, bound, a);
    wait_lvl(1'b0, bound, cyc);
    cyc += a;
  endtask
  initial begin
    csq_host_model_inst.do_reset();
    check_val("ready_n after reset", 1, ready_n);
    hp_cyc = 0;
    lp_cyc = 0;
    fork
      csq_host_model_inst.start(10);
      wait_lvl(1'b0, 3300, c);
    join
    check_rng("request to ready", 3200, 3214, c);
    check_val("high phase", 708, hp_cyc);
    check_val("low phase", 128, lp_cyc);
    check_val("bipolar ceiling", 24'h7fffff, word);
    coding = 1'b0;
    raw = -26'sd5;
    csq_host_model_inst.start(-1);
    wait_lvl(1'b1, 3400, c);
    wait_lvl(1'b0, 20, c);
    check_val("early rise width", 4, c);
    check_val("unipolar floor", 0, word);
    coding = 1'b1;
    raw = 26'sh2000000;
    period(3400, c);
    check_val("back to back period", 3200, c);
    check_val("bipolar floor", 24'h800000, word);
    csq_host_model_inst.loop_back = 1'b1;
    period(7000, c);
    period(7000, c);
    check_val("looped period", 3204, c);
    csq_host_model_inst.loop_back = 1'b0;
    csq_host_model_inst.do_reset();
    check_val("ready_n after reset", 1, ready_n);
    mode = 1'b1;
    coding = 1'b0;
    raw = 26'sh0a5c3e1;
    csq_host_model_inst.start(10);
    wait_lvl(1'b0, 3300, c);
    got = '0;
    r = 1'b0;
    d = 0;
    for (c = 0; c < 200 && d < 24; c++) begin
      @(negedge clk);
      if (sclk === 1'b1 && r === 1'b0) begin
        got = {got[22:0], sdo};
        d++;
      end
      r = sclk;
    end
    check_val("serial word", 24'ha5c3e1, got);
    check_val("sdo enable", 0, oe_n);
    check_val("sclk enable", 0, soe);
    check_val("ready_n at last bit", 0, ready_n);
    wait_lvl(1'b1, 20, c);
    mode = 1'b0;
    csq_host_model_inst.start(-1);
    repeat (200) @(negedge clk);
    check_val("sclk release", 1, soe);
    fork
      csq_host_model_inst.nap(20);
    join_none
    repeat (4) @(negedge clk);
    check_val("sleeping", 1, slp);
    wait_lvl(1'b0, 9500, c);
    check_rng("wake to ready", 9382, 9400, c);
    csq_host_model_inst.mclk_mode = 2'h1;
    repeat (60) @(negedge clk);
    check_val("oscillator on", 1, osc);
    period(7000, c);
    period(7000, c);
    check_val("oscillator period", 6400, c);
    csq_host_model_inst.mclk_mode = 2'h2;
    repeat (60) @(negedge clk);
    check_val("oscillator stopped", 0, osc);
    r = ready_n;
    repeat (7000) @(negedge clk);
    check_val("frozen ready_n", r, ready_n);
    csq_host_model_inst.mclk_mode = 2'h0;
    repeat (60) @(negedge clk);
    check_val("oscillator off", 0, osc);
    period(3400, c);
    period(3400, c);
    check_val("external period", 3200, c);
    give_verdict();
  end
endmodule
`default_nettype wire
